// *** hw/output_voltage_fault_supervisor.sv ***
`timescale 1ns/1ps
`default_nettype none
module output_voltage_fault_supervisor #(
  parameter logic [6:0] BUS_ADDR  = vsup_pkg::BUS_ADDR_RST,
  parameter logic [7:0] VOUT_MODE = vsup_pkg::VOUT_MODE_RST,
  parameter int         UNIT_CYC  = vsup_pkg::RETRY_UNIT_CYC
) (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rst,
  // Management bus pins
  input  wire logic                       smb_clk_i,
  input  wire logic                       smb_data_i,
  output logic                            smb_data_o,
  output logic                            smb_data_oe,
  // Measurement and control
  input  wire logic [vsup_pkg::THR_W-1:0] vout_meas,
  input  wire logic                       vout_meas_valid,
  input  wire logic                       output_cmd_on,
  input  wire logic                       other_fault,
  input  wire logic                       clear_faults,
  // Outputs
  output logic                            output_enable,
  output logic                            alert_line_n,
  output logic                            power_good_out
);
  import vsup_pkg::*;

  logic [15:0] ov_thr_q, uv_thr_q;
  logic [7:0]  ov_resp_q;
  logic        ov_flag_q, uv_flag_q, pg_q;
  logic [2:0]  retry_q, delay_q;
  sup_state_t  st_q, st_d;
  logic        timer_done, clear_evt, bus_clear;

  // Bus pin synchronisers; only the second and third stages feed logic.
  logic [2:0] scl_q, sda_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], smb_clk_i};
      sda_q <= {sda_q[1:0], smb_data_i};
    end
  end
  wire scl_rise = scl_q[1] && !scl_q[2];
  wire scl_fall = !scl_q[1] && scl_q[2];
  wire bus_start = scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1];
  wire bus_stop  = scl_q[1] && scl_q[2] && !sda_q[2] && sda_q[1];

  bus_state_t  bs_q;
  logic [3:0]  bit_q;
  logic        ack_ph_q, idx_q, oe_q;
  logic [7:0]  sh_q, tx_q, cmd_q, wlo_q;

  wire       cmd_known = (sh_q == CMD_OV_THR) || (sh_q == CMD_OV_RESP) || (sh_q == CMD_UV_THR) ||
                         (sh_q == CMD_VOUT_MODE) || (sh_q == CMD_STATUS_VOUT) || (sh_q == CMD_FAULT_CLEAR);
  wire       cmd_wr_ok = (cmd_q == CMD_OV_RESP) ? !idx_q : is_word_cmd(cmd_q);
  wire       wr_commit = (cmd_q == CMD_OV_RESP) || idx_q;
  wire [7:0] status_b  = 8'(({7'h0, ov_flag_q} << STAT_OV_BIT) | ({7'h0, uv_flag_q} << STAT_UV_BIT));
  wire [7:0] rd_word_lo = (cmd_q == CMD_OV_THR) ? ov_thr_q[7:0] : uv_thr_q[7:0];
  wire [7:0] rd_word_hi = (cmd_q == CMD_OV_THR) ? ov_thr_q[15:8] : uv_thr_q[15:8];
  // Word registers go out low byte first; byte registers repeat on extra reads.
  wire [7:0] rd_byte = is_word_cmd(cmd_q)        ? (idx_q ? rd_word_hi : rd_word_lo) :
                       (cmd_q == CMD_OV_RESP)    ? ov_resp_q :
                       (cmd_q == CMD_VOUT_MODE)  ? VOUT_MODE :
                       (cmd_q == CMD_STATUS_VOUT) ? status_b : 8'hFF;
  wire       byte_end = scl_fall && (bit_q == 4'h8) && !ack_ph_q;
  wire       ack_end  = scl_fall && ack_ph_q;

  assign smb_data_o  = 1'b0;
  assign smb_data_oe = oe_q;
  assign bus_clear   = byte_end && (bs_q == BS_CMD) && (sh_q == CMD_FAULT_CLEAR);

  always_ff @(posedge mclk) begin
    if (rst) begin
      bs_q     <= BS_IDLE;
      bit_q    <= 4'h0;
      ack_ph_q <= 1'b0;
      idx_q    <= 1'b0;
      oe_q     <= 1'b0;
      sh_q     <= 8'h00;
      tx_q     <= 8'h00;
      cmd_q    <= 8'h00;
      wlo_q    <= 8'h00;
      ov_thr_q <= OV_THR_RST;
      uv_thr_q <= UV_THR_RST;
      ov_resp_q <= OV_RESP_RST;
    end else if (bus_start) begin
      bs_q     <= BS_ADDR;
      bit_q    <= 4'h0;
      ack_ph_q <= 1'b0;
      idx_q    <= 1'b0;
      oe_q     <= 1'b0;
    end else if (bus_stop) begin
      bs_q <= BS_IDLE;
      oe_q <= 1'b0;
    end else if (scl_rise && bit_q != 4'h8) begin
      sh_q  <= {sh_q[6:0], sda_q[1]};
      bit_q <= bit_q + 4'h1;
    end else if (scl_rise && bs_q == BS_RD && ack_ph_q && sda_q[1]) begin
      bs_q <= BS_SKIP;
    end else if (byte_end) begin
      ack_ph_q <= 1'b1;
      oe_q     <= 1'b0;
      unique case (bs_q)
        BS_ADDR: begin
          oe_q <= (sh_q[7:1] == BUS_ADDR);
          bs_q <= (sh_q[7:1] != BUS_ADDR) ? BS_SKIP : (sh_q[0] ? BS_RD : BS_CMD);
        end
        BS_CMD: begin
          cmd_q <= sh_q;
          oe_q  <= cmd_known;
          bs_q  <= cmd_known ? BS_WR : BS_SKIP;
        end
        BS_WR: begin
          oe_q  <= cmd_wr_ok;
          idx_q <= 1'b1;
          wlo_q <= sh_q;
          if (cmd_wr_ok && wr_commit) begin
            if (cmd_q == CMD_OV_THR) ov_thr_q <= {sh_q, wlo_q};
            if (cmd_q == CMD_UV_THR) uv_thr_q <= {sh_q, wlo_q};
            if (cmd_q == CMD_OV_RESP) ov_resp_q <= sh_q;
          end
        end
        default: ;
      endcase
    end else if (ack_end) begin
      ack_ph_q <= 1'b0;
      bit_q    <= 4'h0;
      oe_q     <= (bs_q == BS_RD) && !rd_byte[7];
      tx_q     <= {rd_byte[6:0], 1'b0};
      if (bs_q == BS_RD) idx_q <= 1'b1;
    end else if (scl_fall && bs_q == BS_RD && bit_q != 4'h8) begin
      oe_q <= !tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // Thresholds and measurement share one number format, so raw mantissas compare directly.
  wire over_v  = vout_meas > ov_thr_q;
  wire under_v = vout_meas < uv_thr_q;
  wire ov_evt  = vout_meas_valid && over_v && (st_q == ST_RUN);
  wire [1:0] resp_mode = ov_resp_q[RESP_MODE_LSB +: 2];
  assign clear_evt = clear_faults || bus_clear;

  // A fault arriving with a clear keeps its flag: the set has priority.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ov_flag_q <= 1'b0;
      uv_flag_q <= 1'b0;
      pg_q      <= 1'b0;
    end else begin
      ov_flag_q <= ov_evt || (ov_flag_q && !clear_evt);
      uv_flag_q <= (vout_meas_valid && under_v && output_enable) || (uv_flag_q && !clear_evt);
      if (vout_meas_valid) pg_q <= !under_v && output_enable;
      if (!output_enable) pg_q <= 1'b0;
    end
  end

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_OFF:   if (output_cmd_on) st_d = ST_RUN;
      ST_RUN: begin
        if (ov_evt && resp_mode == MODE_OFF_RETRY)
          st_d = (retry_q == RETRY_NONE) ? ST_LATCH : ST_WAIT;
        else if (ov_evt && resp_mode == MODE_OFF_WHILE)
          st_d = ST_HOLD;
      end
      ST_WAIT:  if (timer_done) st_d = ST_RUN;
      ST_LATCH: if (clear_evt) st_d = ST_RUN;
      ST_HOLD:  if (vout_meas_valid && !over_v) st_d = ST_RUN;
      default:  st_d = ST_OFF;
    endcase
    if (!output_cmd_on) st_d = ST_OFF;
    else if (other_fault) st_d = ST_LATCH;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q    <= ST_OFF;
      retry_q <= retry_field(OV_RESP_RST);
      delay_q <= 3'h0;
    end else begin
      st_q <= st_d;
      if (st_q != ST_WAIT) delay_q <= ov_resp_q[DELAY_LSB +: 3];
      if (clear_evt) retry_q <= retry_field(ov_resp_q);
      else if (timer_done && retry_q != RETRY_FOREVER) retry_q <= retry_q - 3'h1;
    end
  end

  retry_timer #(
    .UNIT_CYC (UNIT_CYC)
  ) u_retry_timer (
    .mclk  (mclk),
    .rst   (rst),
    .run   (st_q == ST_WAIT),
    .steps (delay_q),
    .done  (timer_done)
  );

  assign output_enable  = (st_q == ST_RUN);
  assign alert_line_n   = !(ov_flag_q || uv_flag_q);
  assign power_good_out = pg_q;

  logic [31:0] wait_cnt_q;
  always_ff @(posedge mclk) begin
    if (rst || st_q != ST_WAIT) wait_cnt_q <= 32'h0;
    else wait_cnt_q <= wait_cnt_q + 32'h1;
  end

  AST_OV_OFF: assert property (@(posedge mclk) disable iff (rst)
    ov_evt && resp_mode == MODE_OFF_RETRY && output_cmd_on && !other_fault |=> !output_enable)
    else $error("output stayed on after overvoltage fault");
  AST_ALERT: assert property (@(posedge mclk) disable iff (rst)
    ov_evt |=> !alert_line_n && ov_flag_q)
    else $error("alert or status missing after fault");
  AST_FLAG_HOLD: assert property (@(posedge mclk) disable iff (rst)
    ov_flag_q && !clear_evt |=> ov_flag_q)
    else $error("fault flag dropped without clear");
  AST_NO_RETRY: assert property (@(posedge mclk) disable iff (rst)
    st_q == ST_LATCH && !clear_evt |=> !output_enable)
    else $error("latched output restarted without clear");
  AST_RETRY_DEC: assert property (@(posedge mclk) disable iff (rst)
    timer_done && !clear_evt && retry_q != RETRY_FOREVER |=> retry_q == $past(retry_q) - 3'h1)
    else $error("retry count not decremented");
  AST_FOREVER: assert property (@(posedge mclk) disable iff (rst)
    timer_done && !clear_evt && retry_q == RETRY_FOREVER && output_cmd_on && !other_fault
    |=> retry_q == RETRY_FOREVER && output_enable)
    else $error("unlimited retry stopped");
  AST_DELAY: assert property (@(posedge mclk) disable iff (rst)
    timer_done |-> wait_cnt_q == (32'(delay_q) + 32'h1) * 32'(UNIT_CYC) - 32'h1)
    else $error("retry delay length wrong");
  AST_PG: assert property (@(posedge mclk) disable iff (rst)
    vout_meas_valid && under_v |=> !power_good_out)
    else $error("power good high below threshold");
  AST_RELOAD: assert property (@(posedge mclk) disable iff (rst)
    clear_evt |=> retry_q == retry_field($past(ov_resp_q)))
    else $error("retry count not reloaded on clear");

  COV_RETRY: cover property (@(posedge mclk) disable iff (rst) st_q == ST_WAIT ##1 st_q == ST_RUN);
  COV_LATCH: cover property (@(posedge mclk) disable iff (rst) st_q == ST_LATCH ##1 st_q == ST_RUN);
  COV_PG:    cover property (@(posedge mclk) disable iff (rst) $rose(power_good_out));
  COV_WRITE: cover property (@(posedge mclk) disable iff (rst) byte_end && bs_q == BS_WR && wr_commit);
endmodule : output_voltage_fault_supervisor
`default_nettype wire

// *** hw/vsup_pkg.sv ***
`default_nettype none
package vsup_pkg;
  localparam int             THR_W            = 16;
  localparam logic [7:0]     CMD_FAULT_CLEAR  = 8'h03;
  localparam logic [7:0]     CMD_VOUT_MODE    = 8'h20;
  localparam logic [7:0]     CMD_OV_THR       = 8'h40;
  localparam logic [7:0]     CMD_OV_RESP      = 8'h41;
  localparam logic [7:0]     CMD_UV_THR       = 8'h44;
  localparam logic [7:0]     CMD_STATUS_VOUT  = 8'h7A;
  localparam int             RESP_MODE_LSB    = 6;
  localparam int             RETRY_LSB        = 3;
  localparam int             DELAY_LSB        = 0;
  localparam logic [1:0]     MODE_OFF_RETRY   = 2'h2;
  localparam logic [1:0]     MODE_OFF_WHILE   = 2'h3;
  localparam logic [2:0]     RETRY_NONE       = 3'h0;
  localparam logic [2:0]     RETRY_FOREVER    = 3'h7;
  localparam logic [15:0]    OV_THR_RST       = 16'hFFFF;
  localparam logic [15:0]    UV_THR_RST       = 16'h0000;
  localparam logic [7:0]     OV_RESP_RST      = 8'h80;
  localparam logic [7:0]     VOUT_MODE_RST    = 8'h00;
  localparam logic [6:0]     BUS_ADDR_RST     = 7'h10;
  localparam int             STAT_OV_BIT      = 7;
  localparam int             STAT_UV_BIT      = 4;
  localparam int             CLK_HZ           = 50_000_000;
  localparam int             RETRY_UNIT_MS    = 35;
  localparam int             RETRY_UNIT_CYC   = CLK_HZ / 1000 * RETRY_UNIT_MS;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_RUN   = 3'b001,
    ST_WAIT  = 3'b010,
    ST_LATCH = 3'b011,
    ST_HOLD  = 3'b100
  } sup_state_t;

  typedef enum logic [2:0] {
    BS_IDLE = 3'b000,
    BS_ADDR = 3'b001,
    BS_CMD  = 3'b010,
    BS_WR   = 3'b011,
    BS_RD   = 3'b100,
    BS_SKIP = 3'b101
  } bus_state_t;

  function automatic logic [2:0] retry_field(input logic [7:0] resp);
    return resp[RETRY_LSB +: 3];
  endfunction : retry_field

  function automatic logic is_word_cmd(input logic [7:0] cmd);
    return (cmd == CMD_OV_THR) || (cmd == CMD_UV_THR);
  endfunction : is_word_cmd
endpackage : vsup_pkg
`default_nettype wire

// *** hw/retry_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module retry_timer #(
  parameter int UNIT_CYC = vsup_pkg::RETRY_UNIT_CYC
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Delay request
  input  wire logic       run,
  input  wire logic [2:0] steps,
  output logic            done
);
  import vsup_pkg::*;

  logic [31:0] unit_q;
  logic [2:0]  step_q;
  wire         unit_end = (unit_q == 32'(UNIT_CYC - 1));

  // Done fires after (steps + 1) whole units of run staying high.
  assign done = run && unit_end && (step_q == steps);

  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      unit_q <= 32'h0;
      step_q <= 3'h0;
    end else if (unit_end) begin
      unit_q <= 32'h0;
      step_q <= step_q + 3'h1;
    end else begin
      unit_q <= unit_q + 32'h1;
    end
  end
endmodule : retry_timer
`default_nettype wire

// *** test/pmbus_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model #(
  parameter logic [6:0] ADDR = 7'h10
) (
  // Clock
  input  wire logic mclk,
  // Bus pins
  input  wire logic sda_level,
  output logic      scl,
  output logic      sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Data moves two clocks after the bus clock falls, so the slave sees it held past its sync delay.
  task automatic bit_io(input logic b, output logic g);
    sda_pull <= ~b;
    repeat (2) @(posedge mclk);
    scl <= 1'b1;
    repeat (2) @(posedge mclk);
    g = sda_level;
    repeat (2) @(posedge mclk);
    scl <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : bit_io
  task automatic start();
    sda_pull <= 1'b0;
    repeat (2) @(posedge mclk);
    scl <= 1'b1;
    repeat (2) @(posedge mclk);
    sda_pull <= 1'b1;
    repeat (4) @(posedge mclk);
    scl <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : start
  task automatic stop();
    sda_pull <= 1'b1;
    repeat (2) @(posedge mclk);
    scl <= 1'b1;
    repeat (4) @(posedge mclk);
    sda_pull <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : stop
  task automatic send(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(d[i], g);
    bit_io(1'b1, g);
    ack = ~g;
  endtask : send
  task automatic recv(input logic last, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, g);
      d[i] = g;
    end
    bit_io(last, g);
  endtask : recv
  task automatic write_cmd(input logic [7:0] c, input logic [15:0] d, input int n, output logic ok);
    logic a;
    start();
    send({ADDR, 1'b0}, ok);
    send(c, a);
    ok = ok & a;
    for (int i = 0; i < n; i++) begin
      send(d[8*i +: 8], a);
      ok = ok & a;
    end
    stop();
  endtask : write_cmd
  // Words come low byte first; the last byte is refused with a NACK.
  task automatic read_cmd(input logic [7:0] c, input int n, output logic [15:0] d);
    logic       a;
    logic [7:0] b;
    d = 16'h0000;
    start();
    send({ADDR, 1'b0}, a);
    send(c, a);
    start();
    send({ADDR, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      recv(i == n - 1, b);
      d[8*i +: 8] = b;
    end
    stop();
  endtask : read_cmd
endmodule : pmbus_host_model
`default_nettype wire

// *** test/output_voltage_fault_supervisor_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module output_voltage_fault_supervisor_tb;
  import vsup_pkg::*;
  localparam int U = 20;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] vm = 16'h0000;
  logic        vm_valid = 1'b0;
  logic        cmd_on = 1'b1;
  logic        other_fault = 1'b0;
  logic        clr = 1'b0;
  logic        scl, sda_pull, sda_o, sda_oe, oe, alert_n, pg, ok;
  wire logic   sda_level = ~(sda_pull | (sda_oe & ~sda_o));
  int          fails = 0;
  int          samples_checked = 0;
  int          n;
  logic [15:0] rd;
  always #10 mclk = ~mclk;
  output_voltage_fault_supervisor #(.UNIT_CYC(U)) dut (
    .mclk(mclk), .rst(rst), .smb_clk_i(scl), .smb_data_i(sda_level),
    .smb_data_o(sda_o), .smb_data_oe(sda_oe), .vout_meas(vm), .vout_meas_valid(vm_valid),
    .output_cmd_on(cmd_on), .other_fault(other_fault), .clear_faults(clr),
    .output_enable(oe), .alert_line_n(alert_n), .power_good_out(pg));
  pmbus_host_model host (.mclk(mclk), .sda_level(sda_level), .scl(scl), .sda_pull(sda_pull));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : tick
  task automatic meas(input logic [15:0] v);
    @(posedge mclk);
    vm <= v;
    vm_valid <= 1'b1;
    @(posedge mclk);
    vm_valid <= 1'b0;
    #1;
  endtask : meas
  task automatic clear_and_set(input logic [7:0] resp);
    // The retry count reloads only on a clear, so the new setting must land before it.
    host.write_cmd(CMD_OV_RESP, {8'h00, resp}, 1, ok);
    chk(16'(ok), 16'h1, "resp write");
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
  endtask : clear_and_set
  // Counts edges with the output off, capped so a latched-off output ends at lim.
  task automatic off_time(input int lim, output int k);
    k = 0;
    while (oe !== 1'b1 && k < lim) begin
      tick(1);
      k++;
    end
  endtask : off_time
  task automatic t_regs();
    host.read_cmd(CMD_OV_THR, 2, rd);
    chk(rd, OV_THR_RST, "ov thr reset");
    host.read_cmd(CMD_OV_RESP, 1, rd);
    chk(rd, {8'h00, OV_RESP_RST}, "resp reset");
    host.read_cmd(CMD_UV_THR, 2, rd);
    chk(rd, UV_THR_RST, "uv thr reset");
    host.write_cmd(CMD_OV_THR, 16'h1234, 2, ok);
    host.write_cmd(CMD_UV_THR, 16'h0100, 2, ok);
    host.write_cmd(CMD_VOUT_MODE, 16'h0055, 1, ok);
    chk(16'(ok), 16'h0, "mode write refused");
    host.read_cmd(CMD_VOUT_MODE, 1, rd);
    chk(rd, {8'h00, VOUT_MODE_RST}, "mode byte");
    host.read_cmd(CMD_OV_THR, 2, rd);
    chk(rd, 16'h1234, "ov thr");
    host.read_cmd(CMD_UV_THR, 2, rd);
    chk(rd, 16'h0100, "uv thr");
  endtask : t_regs
  task automatic t_uv();
    meas(16'h0200);
    tick(1);
    chk(16'({pg, alert_n}), 16'h3, "power good");
    meas(16'h00FF);
    tick(1);
    chk(16'({pg, alert_n}), 16'h0, "under threshold");
    meas(16'h0100);
    tick(1);
    chk(16'(pg), 16'h1, "equal is good");
    host.read_cmd(CMD_STATUS_VOUT, 1, rd);
    chk(16'(rd[STAT_UV_BIT]), 16'h1, "uv status");
  endtask : t_uv
  task automatic t_retry_once();
    clear_and_set(8'h89);
    meas(16'h1234);
    tick(1);
    chk(16'({oe, alert_n}), 16'h3, "equal is no fault");
    meas(16'h1235);
    tick(1);
    chk(16'({oe, alert_n}), 16'h0, "off and alert");
    off_time(300, n);
    chk(16'(n >= 2*U - 1 && n <= 2*U + 1), 16'h1, "retry delay");
    meas(16'h1235);
    off_time(400, n);
    chk(16'(n), 16'd400, "retries used up");
    host.read_cmd(CMD_STATUS_VOUT, 1, rd);
    chk(16'(rd[STAT_OV_BIT]), 16'h1, "ov status");
    clear_and_set(8'h89);
    tick(1);
    chk(16'({oe, alert_n}), 16'h3, "cleared");
    meas(16'h1235);
    tick(1);
    off_time(300, n);
    chk(16'(n >= 2*U - 2 && n <= 2*U + 1), 16'h1, "count reloaded");
  endtask : t_retry_once
  task automatic t_no_retry();
    clear_and_set(8'h87);
    meas(16'h1235);
    off_time(400, n);
    chk(16'(n), 16'd400, "no restart");
    clear_and_set(8'h87);
    tick(1);
    chk(16'(oe), 16'h1, "on after clear");
  endtask : t_no_retry
  task automatic t_forever();
    clear_and_set(8'hBF);
    for (int i = 0; i < 3; i++) begin
      meas(16'h1235);
      off_time(400, n);
      chk(16'(n >= 8*U - 1 && n <= 8*U + 1), 16'h1, "endless retry");
    end
    @(posedge mclk);
    other_fault <= 1'b1;
    @(posedge mclk);
    other_fault <= 1'b0;
    tick(2);
    off_time(400, n);
    chk(16'(n), 16'd400, "other fault stops");
    clear_and_set(8'hBF);
    @(posedge mclk);
    cmd_on <= 1'b0;
    tick(2);
    chk(16'(oe), 16'h0, "commanded off");
    @(posedge mclk);
    cmd_on <= 1'b1;
  endtask : t_forever
  task automatic t_alert_only();
    clear_and_set(8'h09);
    tick(2);
    meas(16'h1235);
    tick(1);
    chk(16'({oe, alert_n}), 16'h2, "alert only");
    // Response mode 11 holds the output off until a measurement is back under the limit.
    clear_and_set(8'hC0);
    tick(1);
    meas(16'h1235);
    tick(1);
    chk(16'({oe, alert_n}), 16'h0, "hold off");
    meas(16'h1000);
    tick(1);
    chk(16'({oe, alert_n}), 16'h2, "hold released");
    host.write_cmd(CMD_FAULT_CLEAR, 16'h0000, 0, ok);
    tick(1);
    chk(16'({ok, alert_n}), 16'h3, "bus clear");
  endtask : t_alert_only
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    tick(5);
    t_regs();
    t_uv();
    t_retry_once();
    t_no_retry();
    t_forever();
    t_alert_only();
    report_and_stop();
  end
  // About twenty bus transfers at some seven microseconds each, with ample margin.
  initial begin
    #1_000_000;
    fails++;
    report_and_stop();
  end
endmodule : output_voltage_fault_supervisor_tb
`default_nettype wire
